// ==== dv/pfta_assertions.sv ====
// Purpose: Port checks of the table access unit
// Assumes: One clock; power-up reset disables checks
// Notes:   Bound to pfta_top below
`timescale 1ns/1ps
module pfta_assertions import pfta_pkg::*; #(
    parameter int P_PROG_CYC = 20
) (
    // Clock and resets
    input wire logic          i_clock,
    input wire logic          i_reset_n,
    input wire logic          i_master_clear_reset,
    input wire logic          i_watchdog_timer_reset,
    // Watched ports
    input wire pfta_sfr_req_t i_sfr,
    input wire logic [7:0]    o_sfr_rdata,
    input wire logic          o_stall,
    input wire logic          i_done_flag_clear,
    input wire logic          o_nonvolatile_write_done_flag,
    input wire logic          o_eeprom_read_start
);
    // ========
    // Helpers
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    logic        rst_hit;
    logic [31:0] run;
    assign rst_hit = i_master_clear_reset | i_watchdog_timer_reset;
    // Stall length, read at its fall
    always_ff @(posedge i_clock) begin
        run <= (!i_reset_n || !o_stall) ? 32'h0 : run + 32'h1;
    end
    sequence s_wr(logic [11:0] a, logic [7:0] m, logic [7:0] v);
        !rst_hit && i_sfr.wr && i_sfr.addr == a && (i_sfr.wdata & m) == v;
    endsequence
    // Core model leaves one idle cycle between two register writes
    sequence s_open;
        !o_stall ##0 s_wr(12'hFA7, 8'hFF, 8'h55) ##2 s_wr(12'hFA7, 8'hFF, 8'hAA);
    endsequence
    // ========
    // Checks
    a_start_stalls: assert property (
        s_open ##2 s_wr(12'hFA6, 8'hC6, 8'h86) |=> o_stall) else $error("no stall");
    a_write_enable_bit_gates: assert property (
        s_open ##2 s_wr(12'hFA6, 8'hC6, 8'h82) |=> !o_stall) else $error("stall no write_enable_bit");
    a_unlock_zero: assert property (
        i_sfr.rd && i_sfr.addr == 12'hFA7 |=> o_sfr_rdata == 8'h00) else $error("unlock read");
    a_rd_refused: assert property (
        s_wr(12'hFA6, 8'h80, 8'h80) |=> !o_eeprom_read_start) else $error("flash read start");
    a_rd_self_clear: assert property (
        o_eeprom_read_start |=> !o_eeprom_read_start) else $error("read start held");
    a_timer_ends: assert property (
        $fell(o_stall) && !$past(rst_hit) |-> run >= P_PROG_CYC) else $error("short cycle");
    a_done_at_end: assert property (
        $fell(o_stall) && !$past(rst_hit) |-> o_nonvolatile_write_done_flag)
        else $error("no done flag");
    a_done_sticky: assert property (
        o_nonvolatile_write_done_flag && !i_done_flag_clear |=> o_nonvolatile_write_done_flag)
        else $error("done flag lost");
endmodule
bind pfta_top pfta_assertions #(.P_PROG_CYC(P_PROG_CYC)) u_chk (.*);

// ==== dv/pfta_core_model.sv ====
// Purpose: Core side issuing register and table operations
// Assumes: Requests start 1 ns after a rising edge
// Notes:   Each request is held for exactly one taking edge
`timescale 1ns/1ps
module pfta_core_model import pfta_pkg::*; (
    // Clock and answers
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    // Requests
    output pfta_sfr_req_t   o_sfr,
    output pfta_table_req_t o_op,
    output logic            o_clear
);
    initial begin
        o_sfr = '0;
        o_op = '0;
        o_clear = 1'b0;
    end
    // Steps off the edge so the taking edge is clean
    task automatic step;
        @(posedge i_clock);
        #1;
    endtask
    // Register access; read data stands the cycle after
    task automatic sfr(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        step();
        o_sfr = '{a, w, !w, d};
        step();
        o_sfr = '{a, 1'b0, 1'b0, ~d};
        q = i_rdata;
    endtask
    task automatic op(input logic w, input pfta_mode_t m);
        step();
        o_op = '{1'b1, w, m};
        step();
        o_op.valid = 1'b0;
    endtask
    task automatic unlock;
        logic [7:0] q;
        sfr(1'b1, 12'hFA7, 8'h55, q);
        sfr(1'b1, 12'hFA7, 8'hAA, q);
    endtask
    task automatic clear;
        step();
        o_clear = 1'b1;
        step();
        o_clear = 1'b0;
    endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: Self-checking bench of the table access unit
// Assumes: Program time cut to 20 cycles
// Notes:   A fetched word puts the even byte low
`timescale 1ns/1ps
module tb import pfta_pkg::*; ();
    // ========
    // Design ports and bench state
    logic            i_clock;
    logic            i_reset_n;
    logic            i_master_clear_reset;
    logic            i_watchdog_timer_reset;
    pfta_sfr_req_t   i_sfr;
    logic [7:0]      o_sfr_rdata;
    pfta_table_req_t i_table_req;
    logic            o_stall;
    logic [20:0]     i_fetch_addr;
    logic [15:0]     o_fetch_word;
    logic            i_done_flag_clear;
    logic            o_nonvolatile_write_done_flag;
    logic            o_eeprom_read_start;
    logic            o_eeprom_write_start;
    int              bad_count;
    int              compares;
    logic            seen;
    logic [20:0]     rows [11];
    pfta_top #(.P_PROG_CYC(20)) dut (.*);
    pfta_core_model u_core (.i_clock(i_clock), .i_rdata(o_sfr_rdata), .o_sfr(i_sfr),
        .o_op(i_table_req), .o_clear(i_done_flag_clear));
    // ========
    // Helpers
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic flag(input logic got, input logic exp);
        cmp({15'h0, got}, {15'h0, exp});
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_core.sfr(1'b1, a, d, q);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_core.sfr(1'b0, a, 8'h00, v);
        cmp({8'h00, v}, {8'h00, exp});
    endtask
    task automatic go(input logic [7:0] c);
        u_core.unlock();
        wr(12'hFA6, c);
    endtask
    // Bounded wait, so a stuck timer shows as a mismatch
    task automatic wait_idle;
        for (int i = 0; i < 40 && o_stall !== 1'b0; i++) begin
            u_core.step();
        end
        flag(o_stall, 1'b0);
    endtask
    task automatic finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ========
    // Clock, watchdog, sequence
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    initial begin
        #8000;
        bad_count++;
        finish_test();
    end
    initial begin
        i_reset_n = 1'b0;
        i_master_clear_reset = 1'b0;
        i_watchdog_timer_reset = 1'b0;
        i_fetch_addr = 21'h8;
        bad_count = 0;
        compares = 0;
        rows = '{21'h0FA600, 21'h0FA700, 21'h0FF500, 21'h0FF600, 21'h0FF700, 21'h0FF800,
            21'h000000, 21'h1FA755, 21'h0FA700, 21'h1FF8FF, 21'h0FF83F};
        repeat (6) @(posedge i_clock);
        #1 i_reset_n = 1'b1;
        // Reset values, upper pointer width, unlock port
        foreach (rows[i]) begin
            if (rows[i][20]) wr(rows[i][19:8], rows[i][7:0]);
            else rchk(rows[i][19:8], rows[i][7:0]);
        end
        // Fill holding bytes; 0001 at 8 is no instruction
        wr(12'hFF8, 8'h00);
        wr(12'hFF6, 8'h08);
        for (int i = 0; i < 8; i++) begin
            wr(12'hFF5, i < 2 ? 8'(1 - i) : 8'(160 + i));
            u_core.op(1'b1, PFTA_POSTINC);
        end
        rchk(12'hFF6, 8'h10);
        wr(12'hFF6, 8'h0B);
        go(8'h86);
        flag(o_stall, 1'b1);
        u_core.step();
        cmp(o_fetch_word, 16'h0000);
        wait_idle();
        flag(o_nonvolatile_write_done_flag, 1'b1);
        rchk(12'hFA6, 8'h84);
        cmp(o_fetch_word, 16'h0000);
        i_fetch_addr = 21'hA;
        u_core.step();
        u_core.step();
        cmp(o_fetch_word, 16'hA3A2);
        // Pointer modes on table reads
        wr(12'hFF6, 8'h0F);
        u_core.op(1'b0, PFTA_POSTDEC);
        rchk(12'hFF5, 8'hA7);
        rchk(12'hFF6, 8'h0E);
        u_core.op(1'b0, PFTA_PREINC);
        rchk(12'hFF5, 8'hA7);
        u_core.op(1'b0, PFTA_KEEP);
        rchk(12'hFF6, 8'h0F);
        u_core.clear();
        flag(o_nonvolatile_write_done_flag, 1'b0);
        // Row erase from a pointer at the row end
        wr(12'hFF6, 8'h3F);
        wr(12'hFA6, 8'h94);
        go(8'h96);
        wait_idle();
        rchk(12'hFA6, 8'h84);
        wr(12'hFF6, 8'h0A);
        u_core.op(1'b0, PFTA_KEEP);
        rchk(12'hFF5, 8'hFF);
        // Refused starts, then reset in mid-write
        wr(12'hFA6, 8'h86);
        flag(o_stall, 1'b0);
        go(8'h82);
        flag(o_stall, 1'b0);
        go(8'h86);
        repeat (3) u_core.step();
        i_master_clear_reset = 1'b1;
        u_core.step();
        i_master_clear_reset = 1'b0;
        u_core.step();
        flag(o_stall, 1'b0);
        rchk(12'hFA6, 8'h88);
        wr(12'hFA6, 8'h01);
        flag(o_eeprom_read_start, 1'b1);
        wr(12'hFA6, 8'h81);
        flag(o_eeprom_read_start, 1'b0);
        // Configuration select overrides a clear memory select; read it back
        wr(12'hFF8, 8'h20);
        go(8'h46);
        flag(o_stall, 1'b1);
        wait_idle();
        wr(12'hFF6, 8'h02);
        u_core.op(1'b0, PFTA_KEEP);
        rchk(12'hFF5, 8'hA2);
        go(8'h06);
        seen = 1'b0;
        repeat (4) begin
            seen |= o_eeprom_write_start;
            u_core.step();
        end
        flag(seen, 1'b1);
        flag(o_stall, 1'b0);
        // Watchdog cut of the running EEPROM write leaves the error flag
        i_watchdog_timer_reset = 1'b1;
        u_core.step();
        i_watchdog_timer_reset = 1'b0;
        rchk(12'hFA6, 8'h08);
        finish_test();
    end
endmodule

// ==== pkg/pfta_defines.svh ====
// Purpose: Constants of the table access unit
// Assumes: 250 MHz core clock
// Notes:   Included by the package and the design
`ifndef PFTA_DEFINES_SVH
`define PFTA_DEFINES_SVH

// ==============================================
// Register addresses
`define PFTA_A_CONTROL 12'hFA6
`define PFTA_A_UNLOCK  12'hFA7
`define PFTA_A_LATCH   12'hFF5
`define PFTA_A_PTRL    12'hFF6
`define PFTA_A_PTRH    12'hFF7
`define PFTA_A_PTRU    12'hFF8

// ==============================================
// Control fields
`define PFTA_B_MEMSEL 7
`define PFTA_B_CFGSEL 6
`define PFTA_B_FREE   4
`define PFTA_B_WRITE_ERROR_FLAG  3
`define PFTA_B_WRITE_ENABLE_BIT   2
`define PFTA_B_WR     1
`define PFTA_B_RD     0

// ==============================================
// Geometry and codes
`define PFTA_PTR_W     22
`define PFTA_LOW_W     21
`define PFTA_FLASH_AW  15
`define PFTA_CFG_AW    4
`define PFTA_KEY1      8'h55
`define PFTA_KEY2      8'hAA
`define PFTA_NOP_WORD  16'h0000
`define PFTA_ERASED    8'hFF
`define PFTA_ZERO8     8'h00

// ==============================================
// Timing
`define PFTA_PROG_TIME_US 2000
`define PFTA_CLK_PS       4000
`define PFTA_PROG_CYC ((`PFTA_PROG_TIME_US * 1000000) / `PFTA_CLK_PS)

`endif

// ==== pkg/pfta_pkg.sv ====
// Purpose: Types and helpers of the table access unit
// Assumes: Defines header on the include path
// Notes:   Pointer steps touch only the low pointer field
`include "pfta_defines.svh"
package pfta_pkg;

    // ==============================================
    // Types
    typedef enum logic [1:0] {
        PFTA_KEEP    = 2'h0,
        PFTA_POSTINC = 2'h1,
        PFTA_POSTDEC = 2'h2,
        PFTA_PREINC  = 2'h3
    } pfta_mode_t;

    typedef enum logic [1:0] {
        PFTA_LOCKED = 2'h0,
        PFTA_HALF   = 2'h1,
        PFTA_OPEN   = 2'h2
    } pfta_unlock_t;

    typedef enum logic [1:0] {
        PFTA_T_EEPROM = 2'h0,
        PFTA_T_FLASH  = 2'h1,
        PFTA_T_CONFIG = 2'h2
    } pfta_target_t;

    typedef struct packed {
        logic       valid;
        logic       is_write;
        pfta_mode_t mode;
    } pfta_table_req_t;

    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } pfta_sfr_req_t;

    // ==============================================
    // Helpers
    // Only the low field moves; the space bit stays
    function automatic logic [`PFTA_PTR_W-1:0] pfta_step(
        input logic [`PFTA_PTR_W-1:0] p,
        input logic                   up);
        logic [`PFTA_LOW_W-1:0] low;
        low = up ? p[`PFTA_LOW_W-1:0] + 21'h1 : p[`PFTA_LOW_W-1:0] - 21'h1;
        return {p[`PFTA_PTR_W-1], low};
    endfunction

    // Reserved opcode patterns cannot execute
    function automatic logic pfta_valid_instr(input logic [15:0] w);
        return !(w[15:4] == 12'h000 && (w[3:0] == 4'h1 || w[3:0] == 4'h2));
    endfunction

    function automatic pfta_target_t pfta_target(input logic m, input logic c);
        return c ? PFTA_T_CONFIG : (m ? PFTA_T_FLASH : PFTA_T_EEPROM);
    endfunction

endpackage

// ==== rtl/pfta_flash_array.sv ====
// Purpose: Byte-organised program flash array
// Assumes: Commits come from the sequencer only
// Notes:   Bytes beyond the array read as erased
`timescale 1ns/1ps
`include "pfta_defines.svh"
module pfta_flash_array import pfta_pkg::*; #(
    parameter int AW = `PFTA_FLASH_AW
) (
    // Clock
    input  wire logic                   i_clock,
    // Byte read port
    input  wire logic [`PFTA_LOW_W-1:0] i_rd_addr,
    output logic      [7:0]             o_rd_byte,
    // Instruction word port
    input  wire logic [`PFTA_LOW_W-1:0] i_fetch_addr,
    output logic      [15:0]            o_fetch_word,
    // Commit port
    input  wire logic                   i_write,
    input  wire logic                   i_erase,
    input  wire logic [`PFTA_LOW_W-1:0] i_addr,
    input  wire logic [63:0]            i_block
);
    logic [7:0] mem [2**AW];

    function automatic logic [7:0] rd(input logic [`PFTA_LOW_W-1:0] a);
        if (|a[`PFTA_LOW_W-1:AW]) begin
            return `PFTA_ERASED;
        end
        return mem[a[AW-1:0]];
    endfunction

    // ==============================================
    // Reads
    assign o_rd_byte    = rd(i_rd_addr);
    assign o_fetch_word = {rd({i_fetch_addr[`PFTA_LOW_W-1:1], 1'b1}),
                           rd({i_fetch_addr[`PFTA_LOW_W-1:1], 1'b0})};

    // ==============================================
    // block and row
    // Write hits an 8-byte block, erase a 64-byte row
    always_ff @(posedge i_clock) begin
        for (int i = 0; i < 64; i++) begin
            if (i_erase && !(|i_addr[`PFTA_LOW_W-1:AW])) begin
                mem[{i_addr[AW-1:6], 6'(i)}] <= `PFTA_ERASED;
            end
            if (i_write && i < 8 && !(|i_addr[`PFTA_LOW_W-1:AW])) begin
                mem[{i_addr[AW-1:3], 3'(i)}] <= i_block[8*i +: 8];
            end
        end
    end
endmodule

// ==== rtl/pfta_top.sv ====
// Purpose: Self-programming table access unit for program flash
// Assumes: Core stalls all table ops and fetches while o_stall is high
// Notes:   Data EEPROM lives outside; only its start pulses leave here
`timescale 1ns/1ps
`include "pfta_defines.svh"
module pfta_top import pfta_pkg::*; #(
    parameter int P_FLASH_AW  = `PFTA_FLASH_AW,
    parameter int P_PROG_CYC  = `PFTA_PROG_CYC
) (
    // Clock and resets
    input  wire logic                   i_clock,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_master_clear_reset,
    input  wire logic                   i_watchdog_timer_reset,
    // Special function register port
    input  wire pfta_sfr_req_t          i_sfr,
    output logic      [7:0]             o_sfr_rdata,
    // Table operations
    input  wire pfta_table_req_t        i_table_req,
    output logic                        o_stall,
    // Instruction fetch
    input  wire logic [`PFTA_LOW_W-1:0] i_fetch_addr,
    output logic      [15:0]            o_fetch_word,
    // Done flag
    input  wire logic                   i_done_flag_clear,
    output logic                        o_nonvolatile_write_done_flag,
    // Data EEPROM starts
    output logic                        o_eeprom_read_start,
    output logic                        o_eeprom_write_start
);
    // ==============================================
    // State
    logic [`PFTA_PTR_W-1:0] table_pointer;
    logic [7:0]             table_latch_byte;
    logic [63:0]            holding;
    logic [7:0]             cfg_mem [2**`PFTA_CFG_AW];
    pfta_unlock_t           unlock;
    logic                   memory_select;
    logic                   configuration_select;
    logic                   row_erase_enable;
    logic                   write_error_flag;
    logic                   write_enable_bit;
    logic                   write_start;
    logic                   read_start;
    logic                   busy;
    logic                   run_erase;
    pfta_target_t           run_target;
    logic [31:0]            prog_count;

    // ==============================================
    // Decode
    logic                   soft_rst;
    logic                   tbl_go;
    logic [`PFTA_PTR_W-1:0] eff_ptr;
    logic [`PFTA_PTR_W-1:0] next_ptr;
    logic                   ctl_wr;
    logic                   unl_wr;
    logic                   start_go;
    logic                   finish;
    logic [7:0]             flash_byte;
    logic [7:0]             src_byte;
    logic [15:0]            flash_word;
    logic [7:0]             ctl_rd;

    assign soft_rst = i_master_clear_reset | i_watchdog_timer_reset;
    assign ctl_wr   = i_sfr.wr && i_sfr.addr == `PFTA_A_CONTROL;
    assign unl_wr   = i_sfr.wr && i_sfr.addr == `PFTA_A_UNLOCK;
    assign tbl_go   = i_table_req.valid && !o_stall;
    assign finish   = busy && prog_count == 32'(P_PROG_CYC - 1);

    assign start_go = ctl_wr && i_sfr.wdata[`PFTA_B_WR] && !busy
                      && unlock == PFTA_OPEN && i_sfr.wdata[`PFTA_B_WRITE_ENABLE_BIT];

    assign eff_ptr = (i_table_req.mode == PFTA_PREINC) ?
                     pfta_step(table_pointer, 1'b1) : table_pointer;

    always_comb begin
        unique case (i_table_req.mode)
            PFTA_POSTINC: next_ptr = pfta_step(table_pointer, 1'b1);
            PFTA_POSTDEC: next_ptr = pfta_step(table_pointer, 1'b0);
            PFTA_PREINC:  next_ptr = eff_ptr;
            PFTA_KEEP:    next_ptr = table_pointer;
        endcase
    end

    // ==============================================
    // Flash array
    pfta_flash_array #(
        .AW (P_FLASH_AW)
    ) u_array (
        .i_clock      (i_clock),
        .i_rd_addr    (eff_ptr[`PFTA_LOW_W-1:0]),
        .o_rd_byte    (flash_byte),
        .i_fetch_addr (i_fetch_addr),
        .o_fetch_word (flash_word),
        .i_write      (finish && run_target == PFTA_T_FLASH && !run_erase),
        .i_erase      (finish && run_target == PFTA_T_FLASH && run_erase),
        .i_addr       (table_pointer[`PFTA_LOW_W-1:0]),
        .i_block      (holding)
    );

    assign src_byte = table_pointer[`PFTA_PTR_W-1] ?
                      cfg_mem[eff_ptr[`PFTA_CFG_AW-1:0]] : flash_byte;

    // ==============================================
    // Table pointer
    // three byte registers
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || soft_rst) begin
            table_pointer <= '0;
        end else if (tbl_go) begin
            table_pointer <= next_ptr;
        end else if (i_sfr.wr) begin
            // Table ops win over a same-cycle register write
            if (i_sfr.addr == `PFTA_A_PTRL) begin
                table_pointer[7:0] <= i_sfr.wdata;
            end else if (i_sfr.addr == `PFTA_A_PTRH) begin
                table_pointer[15:8] <= i_sfr.wdata;
            end else if (i_sfr.addr == `PFTA_A_PTRU) begin
                table_pointer[21:16] <= i_sfr.wdata[5:0];
            end
        end
    end

    // ==============================================
    // Table latch
    // byte through latch
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || soft_rst) begin
            table_latch_byte <= `PFTA_ZERO8;
        end else if (tbl_go && !i_table_req.is_write) begin
            table_latch_byte <= src_byte;
        end else if (i_sfr.wr && i_sfr.addr == `PFTA_A_LATCH) begin
            table_latch_byte <= i_sfr.wdata;
        end
    end

    // ==============================================
    // Holding bytes
    // short write only
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            holding <= '1;
        end else if (tbl_go && i_table_req.is_write) begin
            holding[8*eff_ptr[2:0] +: 8] <= table_latch_byte;
        end
    end

    // ==============================================
    // Configuration space
    // configuration target
    always_ff @(posedge i_clock) begin
        if (finish && run_target == PFTA_T_CONFIG && !run_erase) begin
            for (int i = 0; i < 8; i++) begin
                cfg_mem[{table_pointer[`PFTA_CFG_AW-1:3], 3'(i)}] <= holding[8*i +: 8];
            end
        end
    end

    // ==============================================
    // Unlock sequence
    // key order
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || soft_rst) begin
            unlock <= PFTA_LOCKED;
        end else if (unl_wr) begin
            if (i_sfr.wdata == `PFTA_KEY1) begin
                unlock <= PFTA_HALF;
            end else if (i_sfr.wdata == `PFTA_KEY2 && unlock == PFTA_HALF) begin
                unlock <= PFTA_OPEN;
            end else begin
                unlock <= PFTA_LOCKED;
            end
        end else if (ctl_wr || (i_sfr.wr && unlock != PFTA_OPEN)) begin
            // A control write, or any other write before the pair completes, breaks the key pair
            unlock <= PFTA_LOCKED;
        end
    end

    // ==============================================
    // Selects
    // memory select
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            memory_select        <= 1'b0;
            configuration_select <= 1'b0;
        end else if (ctl_wr && !soft_rst) begin
            memory_select        <= i_sfr.wdata[`PFTA_B_MEMSEL];
            configuration_select <= i_sfr.wdata[`PFTA_B_CFGSEL];
        end
    end

    // ==============================================
    // Enables
    // erase enable
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || soft_rst) begin
            row_erase_enable <= 1'b0;
            write_enable_bit <= 1'b0;
        end else if (finish && run_erase) begin
            row_erase_enable <= 1'b0;
        end else if (ctl_wr) begin
            row_erase_enable <= i_sfr.wdata[`PFTA_B_FREE];
            write_enable_bit <= i_sfr.wdata[`PFTA_B_WRITE_ENABLE_BIT];
        end
    end

    // ==============================================
    // Error flag
    // reset cut write
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            write_error_flag <= 1'b0;
        end else if (soft_rst) begin
            write_error_flag <= busy | write_error_flag;
        end else if (finish) begin
            write_error_flag <= 1'b0;
        end else if (ctl_wr) begin
            write_error_flag <= i_sfr.wdata[`PFTA_B_WRITE_ERROR_FLAG];
        end
    end

    // ==============================================
    // Write start
    // set only
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || soft_rst) begin
            write_start <= 1'b0;
        end else if (start_go) begin
            write_start <= 1'b1;
        end else if (finish) begin
            write_start <= 1'b0;
        end
    end

    // ==============================================
    // Read start
    // one-cycle read
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || soft_rst) begin
            read_start <= 1'b0;
        end else begin
            read_start <= ctl_wr && i_sfr.wdata[`PFTA_B_RD] && !read_start
                          && !i_sfr.wdata[`PFTA_B_MEMSEL] && !busy;
        end
    end
    assign o_eeprom_read_start = read_start;

    // ==============================================
    // Timed cycle
    // timer ends cycle
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || soft_rst) begin
            busy       <= 1'b0;
            run_erase  <= 1'b0;
            run_target <= PFTA_T_EEPROM;
            prog_count <= '0;
        end else if (start_go) begin
            busy       <= 1'b1;
            run_erase  <= i_sfr.wdata[`PFTA_B_FREE];
            run_target <= pfta_target(i_sfr.wdata[`PFTA_B_MEMSEL],
                                      i_sfr.wdata[`PFTA_B_CFGSEL]);
            prog_count <= '0;
        end else if (finish) begin
            busy <= 1'b0;
        end else if (busy) begin
            prog_count <= prog_count + 32'h1;
        end
    end

    // EEPROM array is outside; it only hears the start
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_eeprom_write_start <= 1'b0;
        end else begin
            o_eeprom_write_start <= start_go && !i_sfr.wdata[`PFTA_B_CFGSEL]
                                    && !i_sfr.wdata[`PFTA_B_MEMSEL];
        end
    end

    assign o_stall = busy && run_target != PFTA_T_EEPROM;

    // ==============================================
    // Done flag
    // set beats clear
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_nonvolatile_write_done_flag <= 1'b0;
        end else if (finish) begin
            o_nonvolatile_write_done_flag <= 1'b1;
        end else if (i_done_flag_clear) begin
            o_nonvolatile_write_done_flag <= 1'b0;
        end
    end

    // ==============================================
    // Fetch
    // invalid word as no-op
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || o_stall || !pfta_valid_instr(flash_word)) begin
            o_fetch_word <= `PFTA_NOP_WORD;
        end else begin
            o_fetch_word <= flash_word;
        end
    end

    // ==============================================
    // Register reads
    assign ctl_rd = {memory_select, configuration_select, 1'b0, row_erase_enable,
                     write_error_flag, write_enable_bit, write_start, read_start};

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_sfr_rdata <= `PFTA_ZERO8;
        end else if (!i_sfr.rd) begin
            o_sfr_rdata <= `PFTA_ZERO8;
        end else begin
            unique case (i_sfr.addr)
                `PFTA_A_CONTROL: o_sfr_rdata <= ctl_rd;
                `PFTA_A_LATCH:   o_sfr_rdata <= table_latch_byte;
                `PFTA_A_PTRL:    o_sfr_rdata <= table_pointer[7:0];
                `PFTA_A_PTRH:    o_sfr_rdata <= table_pointer[15:8];
                `PFTA_A_PTRU:    o_sfr_rdata <= {2'h0, table_pointer[21:16]};
                default:         o_sfr_rdata <= `PFTA_ZERO8;
            endcase
        end
    end
endmodule
